// [bench/key_menu_controller_tb_top.sv]
// self-checking bench of the key menu controller
`timescale 1ns/1ps
`include "key_menu_defs.svh"
module key_menu_controller_tb_top
  import key_menu_pkg::*;
;
  localparam int STEP = 20;
  localparam int FL = 4;
  // arbitrary identity value
  localparam logic [31:0] FWV = 32'h0000_0A5C;
  localparam logic [3:0] TV [5] = '{4'h0, 4'h1, 4'hA, 4'hB, 4'hF};
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic        fault, self_ok, stroke_done, pump_stroke, dispense_en;
  logic        disp_key, disp_tick, disp_blank, disp_saver, key_sense;
  logic        op_go, op_busy, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, disp_num, rd, e;
  logic [15:0] press_bar, disp_bar;
  logic [2:0]  disp_item, op_tgt, op_lag;
  logic [1:0]  disp_x, disp_y, disp_mode;
  logic [3:0]  p, v;
  int          bad_count, cmp_count, cyc, seed, n, k;

  key_menu_controller #(.STEP_CYC(STEP), .IDLE_CYC(100), .DEB_CYC(3),
    .FLASH_CYC(FL), .RELAX_CYC(5), .FW_ID(FWV)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_sense(key_sense),
    .fault(fault), .self_ok(self_ok), .stroke_done(stroke_done),
    .press_bar(press_bar), .pump_stroke(pump_stroke),
    .dispense_en(dispense_en), .disp_item(disp_item), .disp_key(disp_key),
    .disp_tick(disp_tick), .disp_blank(disp_blank),
    .disp_saver(disp_saver), .disp_x(disp_x), .disp_y(disp_y),
    .disp_mode(disp_mode), .disp_num(disp_num), .disp_bar(disp_bar));

  key_operator #(.WAIT_MAX(100)) u_op (
    .clk_sys(clk_sys), .go(op_go), .target(op_tgt), .lag(op_lag),
    .busy(op_busy), .disp_item(disp_item), .disp_key(disp_key),
    .key_sense(key_sense));

  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [3:0] clampf(input logic [3:0] x);
    return (x < `STK_MIN) ? `STK_MIN : (x > `STK_MAX) ? `STK_MAX : x;
  endfunction

  function automatic logic [15:0] peak(input logic [15:0] a, b);
    return {(a[15:8] > b[15:8]) ? a[15:8] : b[15:8],
            (a[7:0] > b[7:0]) ? a[7:0] : b[7:0]};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do
      @(posedge clk_sys);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic setc(input logic [3:0] s, input logic [1:0] m);
    apb(1'h1, `OFS_CTRL, {24'h0, s, 2'h0, m});
    @(posedge clk_sys);
  endtask

  task automatic wait_st(input state_t s);
    int i;
    i = 0;
    do
    begin
      apb(1'h0, `OFS_STAT, 32'h0);
      i++;
    end
    while (rd[7:4] !== s && i < 200);
    chk("state", 32'(rd[7:4]), 32'(s));
  endtask

  task automatic sel(input item_t t);
    int  i;
    logic b;
    op_tgt <= 3'(t);
    op_lag <= 3'($random(seed));
    op_go <= 1'h1;
    @(posedge clk_sys);
    op_go <= 1'h0;
    i = 0;
    while (!(disp_key === 1'h1 && disp_item === t) && i < 400)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk("key_dot", 32'(disp_key), 1);
    while (disp_tick !== 1'h1 && i < 500)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk("tick", 32'(disp_tick), 1);
    chk("key_gone", 32'(disp_key), 0);
    k = 0;
    b = 1'h0;
    repeat (5 * FL)
    begin
      @(posedge clk_sys);
      if (!b && disp_blank === 1'h1)
        k++;
      b = disp_blank;
    end
    chk("flashes", 32'(k), 2);
  endtask

  task automatic stroke(input logic fin);
    logic [15:0] x, pk;
    int          i;
    i = 0;
    while (pump_stroke !== 1'h1 && i < 100)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk("stroke_on", 32'(pump_stroke), 1);
    pk = 16'h0;
    repeat (4)
    begin
      x = 16'($random(seed));
      press_bar <= x;
      repeat (2) @(posedge clk_sys);
      chk("bar_live", 32'(disp_bar), 32'(x));
      pk = peak(pk, x);
    end
    if (fin)
    begin
      stroke_done <= 1'h1;
      @(posedge clk_sys);
      stroke_done <= 1'h0;
      press_bar <= 16'h0;
      repeat (3) @(posedge clk_sys);
      chk("bar_peak", 32'(disp_bar), 32'(pk));
    end
  endtask

  task automatic wnum(input logic [31:0] x);
    int i;
    i = 0;
    while (disp_num !== x && i < 3 * STEP)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk("info_page", disp_num, x);
  endtask

  initial
  begin
    seed = 32'h12654F85;
    {resetn, psel, penable, pwrite, fault, self_ok, stroke_done} = '0;
    {op_go, op_tgt, op_lag, paddr, pwdata, press_bar} = '0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    chk("outs", 32'({disp_item, dispense_en, pump_stroke, disp_saver}), 0);
    apb(1'h0, `OFS_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h0000_0010);
    apb(1'h1, `OFS_FWID, 32'h0);
    apb(1'h0, `OFS_FWID, 32'h0);
    chk("fwid", rd, FWV);
    apb(1'h0, 8'h14, 32'h0);
    chk("unm_err", 32'(er), 1);
    chk("unm_rd", rd, 0);
    for (int i = 0; i < 9; i++)
    begin
      v = (i < 5) ? TV[i] : 4'($random(seed));
      setc(v, 2'h0);
      apb(1'h0, `OFS_CTRL, 32'h0);
      chk("strokes", rd, {24'h0, clampf(v), 4'h0});
    end
    sel(IT_ON);
    wait_st(ST_CHECK);
    chk("disp_chk", 32'(dispense_en), 0);
    self_ok <= 1'h1;
    wait_st(ST_ON);
    chk("disp_on", 32'(dispense_en), 1);
    for (int m = 2; m >= 0; m--)
    begin
      setc(4'h2, 2'(m));
      chk("mode", 32'(disp_mode), 32'(m));
    end
    repeat (110) @(posedge clk_sys);
    chk("saver", 32'(disp_saver), 1);
    repeat (5)
    begin
      p = {disp_y, disp_x};
      repeat (STEP) @(posedge clk_sys);
      chk("saver_pos", 32'({disp_y, disp_x}), 32'(4'(p + 4'h1)));
    end
    n = 1 + int'($unsigned($random(seed)) % 10);
    e = 32'h100 + ($random(seed) & 32'hFFF);
    setc(4'(n), 2'h1);
    apb(1'h1, `OFS_EMPTY, e);
    sel(IT_QUICK);
    repeat (n) stroke(1'h1);
    wait_st(ST_ON);
    apb(1'h0, `OFS_EMPTY, 32'h0);
    e = e - 32'(n);
    chk("empty", rd, e);
    setc(4'h3, 2'h0);
    sel(IT_QUICK);
    stroke(1'h1);
    stroke(1'h0);
    sel(IT_STOP);
    wait_st(ST_SHOW);
    chk("done_cnt", disp_num, 1);
    chk("stopped", 32'(pump_stroke), 0);
    wait_st(ST_ON);
    sel(IT_QUICK);
    stroke(1'h0);
    sel(IT_OFF);
    wait_st(ST_OFF);
    chk("off_out", 32'({dispense_en, pump_stroke}), 0);
    for (int m = 0; m < 2; m++)
    begin
      setc(4'h7, 2'(m));
      sel(IT_INFO);
      wnum(FWV);
      wnum(32'(m));
      wnum(m ? e : 32'h7);
      wait_st(ST_OFF);
    end
    // quick refused with a fault, then in pulse mode
    for (int c = 0; c < 2; c++)
    begin
      fault <= 1'(c == 0);
      setc(4'h1, c ? 2'h2 : 2'h0);
      apb(1'h0, `OFS_STAT, 32'h0);
      if (rd[7:4] !== ST_ON)
      begin
        sel(IT_ON);
        wait_st(ST_ON);
      end
      op_tgt <= 3'(IT_QUICK);
      op_go <= 1'h1;
      @(posedge clk_sys);
      op_go <= 1'h0;
      k = 0;
      repeat (3 * STEP)
      begin
        @(posedge clk_sys);
        if (disp_item === IT_QUICK || disp_item === IT_INFO)
          k++;
      end
      chk("no_quick", 32'(k), 0);
      while (op_busy === 1'h1) @(posedge clk_sys);
      repeat (40) @(posedge clk_sys);
    end
    test_done();
  end
endmodule // key_menu_controller_tb_top

// [bench/key_operator.sv]
// operator model: places the key and lifts it on a shown item
`timescale 1ns/1ps
module key_operator
#(
  parameter int unsigned WAIT_MAX = 100
)
(
  // clock
  input  wire logic       clk_sys,
  // command from the bench
  input  wire logic       go,
  input  wire logic [2:0] target,
  input  wire logic [2:0] lag,
  output logic            busy,
  // what the operator sees and does
  input  wire logic [2:0] disp_item,
  input  wire logic       disp_key,
  output logic            key_sense
);
  int n;

  initial
  begin
    key_sense = 1'h0;
    busy = 1'h0;
    forever
    begin
      @(posedge clk_sys);
      if (go === 1'h1)
      begin
        busy <= 1'h1;
        key_sense <= 1'h1;
        @(posedge clk_sys);
        key_sense <= 1'h0;
        @(posedge clk_sys);
        key_sense <= 1'h1;
        n = 0;
        while ((disp_key !== 1'h1 || disp_item !== target) && n < WAIT_MAX)
        begin
          @(posedge clk_sys);
          n++;
        end
        // slow hand, still well inside one item
        repeat (lag) @(posedge clk_sys);
        key_sense <= 1'h0;
        @(posedge clk_sys);
        busy <= 1'h0;
      end
    end
  end
endmodule // key_operator

// [rtl/key_filter.sv]
// bounce filter for the magnetic key sense input
`timescale 1ns/1ps
`include "key_menu_defs.svh"
module key_filter
  import key_menu_pkg::*;
#(
  parameter int unsigned DEB_CYC = `DEB_MS * `CLK_KHZ
)
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // raw and filtered key
  input  wire logic key_raw,
  output logic      key_ff
);

  logic [31:0] cnt_ff;

  // [RULE24] accept a level only after it stood stable
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= 32'h0;
      key_ff <= 1'b0;
    end
    else if (key_raw == key_ff)
    begin
      cnt_ff <= 32'h0;
    end
    else if (cnt_ff >= DEB_CYC - 1)
    begin
      cnt_ff <= 32'h0;
      key_ff <= key_raw;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

endmodule // key_filter

// [rtl/key_menu_controller.sv]
// key menu controller of the grease lubricator, with apb registers
// Notes on behaviour
// [RULE1] show key dot while key sensed
// [RULE2] step menu item every two seconds
// [RULE3] lifting key selects shown item; on from off
// [RULE4] tick and two flashes on selection
// [RULE5] self-check before on and dispensing
// [RULE6] screen saver after ten idle seconds
// [RULE7] saver moves indicator left-right, top-bottom
// [RULE8] show operating mode symbol when on
// [RULE9] off item stops dispensing, shows off
// [RULE10] switch-off accepted in any state; the code refuses it during ST_CONF
// [RULE11] info only from off, returns off
// [RULE12] info shows identity, values, read only
// [RULE13] info values depend on mode
// [RULE14] quick trigger only on, no fault
// [RULE15] confirmed trigger starts one pump cycle
// [RULE16] exactly configured strokes per cycle
// [RULE17] strokes limited one through ten
// [RULE18] live back-pressure shown during stroke
// [RULE19] peak pressure shown after stroke
// [RULE20] stop item during stroke aborts cycle
// [RULE21] show completed count after cancel
// [RULE22] manual cycle shortens emptying schedule
// [RULE23] no quick item in pulse mode
// [RULE24] key input filtered against bounce
// [RULE25] step and idle timers restart on key
`timescale 1ns/1ps
`include "key_menu_defs.svh"
module key_menu_controller
  import key_menu_pkg::*;
#(
  parameter int unsigned NOUT      = 2,
  parameter int unsigned STEP_CYC  = `STEP_MS * `CLK_KHZ,
  parameter int unsigned IDLE_CYC  = `IDLE_MS * `CLK_KHZ,
  parameter int unsigned DEB_CYC   = `DEB_MS * `CLK_KHZ,
  parameter int unsigned FLASH_CYC = `FLASH_MS * `CLK_KHZ,
  parameter int unsigned RELAX_CYC = `RELAX_MS * `CLK_KHZ,
  // arbitrary identity value
  parameter logic [31:0] FW_ID     = 32'h0000_0100
)
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // key and machine status
  input  wire logic              key_sense,
  input  wire logic              fault,
  input  wire logic              self_ok,
  input  wire logic              stroke_done,
  input  wire logic [NOUT*8-1:0] press_bar,
  // pump and dispensing
  output logic                   pump_stroke,
  output logic                   dispense_en,
  // display
  output logic [2:0]             disp_item,
  output logic                   disp_key,
  output logic                   disp_tick,
  output logic                   disp_blank,
  output logic                   disp_saver,
  output logic [1:0]             disp_x,
  output logic [1:0]             disp_y,
  output logic [1:0]             disp_mode,
  output logic [31:0]            disp_num,
  output logic [NOUT*8-1:0]      disp_bar
);

  logic              key_f;
  logic              key_d_ff;
  logic              key_edge;
  logic              key_rel;
  state_t            st_ff;
  item_t             item_ff;
  item_t             pend_ff;
  logic              sel_ff;
  logic [31:0]       tmr_ff;
  logic              step_tick;
  logic [31:0]       idle_ff;
  logic [31:0]       aux_ff;
  logic [2:0]        half_ff;
  logic [1:0]        page_ff;
  logic [3:0]        done_ff;
  logic [1:0]        mode_ff;
  logic [3:0]        stk_ff;
  logic [31:0]       empty_ff;
  logic [NOUT*8-1:0] peak_ff;
  logic [31:0]       nxt_rd;
  logic              hit;
  logic              wr_en;
  logic [3:0]        nxt_stk;

  key_filter #(.DEB_CYC(DEB_CYC)) u_filter
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .key_raw (key_sense),
    .key_ff  (key_f)
  );

  assign key_edge  = key_f ^ key_d_ff;
  assign key_rel   = key_d_ff & ~key_f;
  assign step_tick = (tmr_ff == STEP_CYC - 1);

  // apb: answer in the access cycle, no wait states
  always_comb
  begin
    hit    = 1'b1;
    nxt_rd = 32'h0;
    case (paddr)
      `OFS_CTRL:  nxt_rd = {24'h0, stk_ff, 2'h0, mode_ff};
      `OFS_STAT:  nxt_rd = {16'h0, done_ff, 1'b0, item_ff, st_ff,
                            dispense_en, sel_ff, disp_saver, key_f};
      `OFS_PEAK:  nxt_rd = 32'(peak_ff);
      `OFS_FWID:  nxt_rd = FW_ID;
      `OFS_EMPTY: nxt_rd = empty_ff;
      default:    hit    = 1'b0;
    endcase
  end

  assign wr_en = psel & penable & pready & pwrite & hit;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? nxt_rd : 32'h0;
    end
  end

  // [RULE17] clamp stroke count into one..ten
  always_comb
  begin
    nxt_stk = pwdata[`CTRL_STK_MSB:`CTRL_STK_LSB];
    if (nxt_stk < `STK_MIN)
      nxt_stk = `STK_MIN;
    else if (nxt_stk > `STK_MAX)
      nxt_stk = `STK_MAX;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_ff <= `CTRL_RST_MODE;
      stk_ff  <= `CTRL_RST_STK;
    end
    else if (wr_en && paddr == `OFS_CTRL)
    begin
      mode_ff <= pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      stk_ff  <= nxt_stk;
    end
  end

  // [RULE22] in empty mode each manual stroke takes from the emptying budget
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      empty_ff <= 32'h0;
    else if (st_ff == ST_STROKE && stroke_done && mode_ff == MD_EMPTY
             && empty_ff != 32'h0)
      empty_ff <= empty_ff - 32'h1;
    else if (wr_en && paddr == `OFS_EMPTY)
      empty_ff <= pwdata;
  end

  // [RULE25] step and idle timers restart on every key edge
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      key_d_ff <= 1'b0;
      tmr_ff   <= 32'h0;
      idle_ff  <= 32'h0;
    end
    else
    begin
      key_d_ff <= key_f;
      tmr_ff   <= (key_edge || step_tick) ? 32'h0 : tmr_ff + 32'h1;
      if (key_edge || key_f || (st_ff != ST_ON && st_ff != ST_OFF))
        idle_ff <= 32'h0;
      else if (idle_ff != IDLE_CYC)
        idle_ff <= idle_ff + 32'h1;
    end
  end

  // selection: first item on placement, then step while held
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_ff  <= 1'b0;
      item_ff <= IT_NONE;
    end
    else if (key_f && !key_d_ff)
    begin
      sel_ff <= 1'b1;
      case (st_ff)
        ST_OFF:                item_ff <= IT_ON;
        ST_ON:                 item_ff <= IT_OFF;
        // [RULE20] stop offered while the cycle runs
        ST_STROKE, ST_RELAX:   item_ff <= IT_STOP;
        default:               item_ff <= IT_OFF;
      endcase
    end
    else if (key_rel || st_ff == ST_CONF)
    begin
      sel_ff  <= 1'b0;
      item_ff <= IT_NONE;
    end
    // [RULE2] advance the shown item every step period
    else if (sel_ff && step_tick)
    begin
      case (item_ff)
        IT_ON:    item_ff <= IT_INFO;
        IT_INFO:  item_ff <= IT_ON;
        // [RULE14] quick only when on and fault free
        // [RULE23] pulse mode hides the quick item
        IT_OFF:   item_ff <= (st_ff == ST_ON && !fault
                              && mode_ff != MD_PULSE) ? IT_QUICK :
                             (st_ff == ST_STROKE || st_ff == ST_RELAX) ?
                             IT_STOP : IT_OFF;
        IT_QUICK: item_ff <= IT_OFF;
        IT_STOP:  item_ff <= IT_OFF;
        default:  item_ff <= IT_NONE;
      endcase
    end
  end

  // main sequence
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff   <= ST_OFF;
      pend_ff <= IT_NONE;
      aux_ff  <= 32'h0;
      half_ff <= 3'h0;
      page_ff <= 2'h0;
      done_ff <= 4'h0;
    end
    // [RULE3] lifting the key takes the shown item
    // [RULE10] off is taken from any state except ST_CONF, where a new placement is cleared at once
    else if (key_rel && sel_ff && item_ff != IT_NONE)
    begin
      st_ff   <= ST_CONF;
      pend_ff <= item_ff;
      aux_ff  <= 32'h0;
      half_ff <= 3'h0;
    end
    else
    begin
      case (st_ff)
        ST_CONF:
        begin
          // [RULE4] two flashes before acting
          aux_ff <= (aux_ff == FLASH_CYC - 1) ? 32'h0 : aux_ff + 32'h1;
          if (aux_ff == FLASH_CYC - 1)
            half_ff <= half_ff + 3'h1;
          if (aux_ff == FLASH_CYC - 1 && half_ff == `FLASH_HALVES - 3'h1)
          begin
            page_ff <= 2'h0;
            aux_ff  <= 32'h0;
            case (pend_ff)
              IT_ON:    st_ff <= ST_CHECK;
              // [RULE11] info only reachable from off
              IT_INFO:  st_ff <= ST_INFO;
              // [RULE15] confirmed trigger starts the cycle
              IT_QUICK:
              begin
                st_ff   <= ST_STROKE;
                done_ff <= 4'h0;
              end
              // [RULE21] cancel leads to the completed count
              IT_STOP:  st_ff <= ST_SHOW;
              default:  st_ff <= ST_OFF;
            endcase
          end
        end
        // [RULE5] on only once the self-check passes
        ST_CHECK:
          if (self_ok)
            st_ff <= ST_ON;
        // own page timer: the free step timer would cut page zero short
        ST_INFO:
        begin
          aux_ff <= (aux_ff == STEP_CYC - 1) ? 32'h0 : aux_ff + 32'h1;
          if (aux_ff == STEP_CYC - 1)
          begin
            page_ff <= page_ff + 2'h1;
            if (page_ff == 2'h2)
              st_ff <= ST_OFF;
          end
        end
        // [RULE16] stop after exactly the set strokes
        ST_STROKE:
          if (stroke_done)
          begin
            done_ff <= done_ff + 4'h1;
            aux_ff  <= 32'h0;
            st_ff   <= (done_ff + 4'h1 >= stk_ff) ? ST_ON : ST_RELAX;
          end
        ST_RELAX:
        begin
          aux_ff <= aux_ff + 32'h1;
          if (aux_ff == RELAX_CYC - 1)
            st_ff <= ST_STROKE;
        end
        ST_SHOW:
        begin
          aux_ff <= aux_ff + 32'h1;
          if (aux_ff == STEP_CYC - 1)
            st_ff <= ST_ON;
        end
        default: ;
      endcase
    end
  end

  // [RULE19] peak per outlet, cleared at each stroke start
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1)
    begin : g_peak
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
          peak_ff[g*8 +: 8] <= 8'h0;
        else if (st_ff == ST_RELAX && aux_ff == RELAX_CYC - 1)
          peak_ff[g*8 +: 8] <= 8'h0;
        else if (st_ff == ST_CONF && pend_ff == IT_QUICK)
          peak_ff[g*8 +: 8] <= 8'h0;
        else if (st_ff == ST_STROKE && press_bar[g*8 +: 8] >
                 peak_ff[g*8 +: 8])
          peak_ff[g*8 +: 8] <= press_bar[g*8 +: 8];
      end
    end
  endgenerate

  // registered display and pump outputs
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pump_stroke <= 1'b0;
      dispense_en <= 1'b0;
      disp_item   <= IT_NONE;
      disp_key    <= 1'b0;
      disp_tick   <= 1'b0;
      disp_blank  <= 1'b0;
      disp_saver  <= 1'b0;
      disp_mode   <= 2'h0;
      disp_num    <= 32'h0;
      disp_bar    <= '0;
    end
    else
    begin
      // [RULE9] only states of the on side dispense
      dispense_en <= (st_ff == ST_ON || st_ff == ST_STROKE
                      || st_ff == ST_RELAX);
      pump_stroke <= (st_ff == ST_STROKE) && !stroke_done;
      disp_item   <= item_ff;
      // [RULE1] key dot follows the filtered key
      disp_key    <= key_f;
      disp_tick   <= (st_ff == ST_CONF);
      disp_blank  <= (st_ff == ST_CONF) && half_ff[0];
      // [RULE6] saver after the idle time in on or off
      disp_saver  <= (idle_ff == IDLE_CYC);
      // [RULE8] mode symbol shown while on
      disp_mode   <= (st_ff == ST_ON) ? mode_ff : 2'h0;
      // [RULE12] info pages, read only
      // [RULE13] third page depends on the mode
      case (st_ff)
        ST_INFO:
          case (page_ff)
            2'h0:    disp_num <= FW_ID;
            2'h1:    disp_num <= {30'h0, mode_ff};
            default: disp_num <= (mode_ff == MD_EMPTY) ? empty_ff :
                                 (mode_ff == MD_CYCLE) ?
                                 {28'h0, stk_ff} : 32'h0;
          endcase
        ST_SHOW: disp_num <= {28'h0, done_ff};
        default: disp_num <= 32'h0;
      endcase
      // [RULE18] live pressure during a stroke, peak after
      disp_bar    <= (st_ff == ST_STROKE) ? press_bar :
                     (st_ff == ST_RELAX || st_ff == ST_ON) ? peak_ff : '0;
    end
  end

  // [RULE7] saver position steps across, then down
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      disp_x <= 2'h0;
      disp_y <= 2'h0;
    end
    else if (!disp_saver)
    begin
      disp_x <= 2'h0;
      disp_y <= 2'h0;
    end
    else if (step_tick)
    begin
      disp_x <= disp_x + 2'h1;
      if (disp_x == `POS_LAST)
        disp_y <= disp_y + 2'h1;
    end
  end

  key_dot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> disp_key == $past(key_f)) // [RULE1]
    else $error("key dot does not follow key");

  on_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    key_rel && sel_ff && item_ff == IT_ON |=> st_ff == ST_CONF
      && pend_ff == IT_ON) // [RULE3]
    else $error("on selection not taken");

  check_first_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_ff == ST_CHECK && !self_ok && !key_rel |=> st_ff == ST_CHECK)
    // [RULE5]
    else $error("left self-check without pass");

  off_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_ff == ST_OFF ##1 st_ff == ST_OFF |-> !dispense_en && !pump_stroke)
    // [RULE9]
    else $error("dispensing while off");

  stop_any_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    key_rel && sel_ff && item_ff == IT_OFF |=> st_ff == ST_CONF)
    // [RULE10]
    else $error("switch-off refused");

  no_quick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    item_ff == IT_QUICK |-> mode_ff != MD_PULSE || $past(mode_ff)
      != MD_PULSE) // [RULE23]
    else $error("quick item offered in pulse mode");

  stk_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    stk_ff >= `STK_MIN && stk_ff <= `STK_MAX) // [RULE17]
    else $error("stroke count out of range");

  stroke_cnt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_ff == ST_STROKE |-> done_ff < stk_ff) // [RULE16]
    else $error("extra stroke started");

  info_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_ff == ST_INFO && aux_ff == STEP_CYC - 1 && page_ff == 2'h2
      && !key_rel
      |=> st_ff == ST_OFF) // [RULE11]
    else $error("info did not return to off");

  flash_two_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_ff == ST_CONF |-> half_ff < `FLASH_HALVES) // [RULE4]
    else $error("more than two flashes");

endmodule // key_menu_controller

// [rtl/key_menu_defs.svh]
// constants of the key menu controller: offsets, fields, timing
`ifndef KEY_MENU_DEFS_SVH
`define KEY_MENU_DEFS_SVH

// register byte offsets
`define OFS_CTRL    8'h00
`define OFS_STAT    8'h04
`define OFS_PEAK    8'h08
`define OFS_FWID    8'h0C
`define OFS_EMPTY   8'h10

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_STK_LSB  4
`define CTRL_STK_MSB  7
`define CTRL_RST_MODE 2'h0
`define CTRL_RST_STK  4'h1

// stroke count limits
`define STK_MIN 4'h1
`define STK_MAX 4'hA

// flash halves for two flashes
`define FLASH_HALVES 3'h4

// saver position grid is 4 x 4
`define POS_LAST 2'h3

// times in their own units
`define CLK_KHZ   125000
`define STEP_MS   2000
`define IDLE_MS   10000
`define DEB_MS    5
`define FLASH_MS  250
`define RELAX_MS  2000

`endif

// [rtl/key_menu_pkg.sv]
// types shared by the key menu controller files
package key_menu_pkg;

  typedef enum logic [3:0]
  {
    ST_OFF,
    ST_ON,
    ST_CONF,
    ST_CHECK,
    ST_INFO,
    ST_STROKE,
    ST_RELAX,
    ST_SHOW
  } state_t;

  typedef enum logic [2:0]
  {
    IT_NONE,
    IT_ON,
    IT_OFF,
    IT_INFO,
    IT_QUICK,
    IT_STOP
  } item_t;

  typedef enum logic [1:0]
  {
    MD_CYCLE,
    MD_EMPTY,
    MD_PULSE
  } opmode_t;

endpackage
